// ==== rtl/ppm_map.svh ====
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH

// Register indexes; the byte address is four times the index
`define PPM_IDX_CSR 8'hA4
`define PPM_IDX_BRG 8'hA6
`define PPM_IDX_DATA 8'hA7

// Field positions of the control/status register
`define PPM_BIT_STATUS 15
`define PPM_BIT_ENABLE 8
`define PPM_PS_HI 1
`define PPM_PS_LO 0

// Field positions of the bridge extensions register
`define PPM_BIT_BPCC 7
`define PPM_BIT_B2B3 6

// Reset values
`define PPM_CSR_RST 16'h0000
`define PPM_BRG_RST 8'hC0
`define PPM_DATA_RST 8'h00

// Power state encodings
`define PPM_PS_D0 2'h0
`define PPM_PS_D1 2'h1
`define PPM_PS_D2 2'h2
`define PPM_PS_D3 2'h3

// Length of the internal function reset pulse, in clock cycles
`define PPM_RST_PULSE_CYC 1

`endif

// ==== rtl/ppm_pkg.sv ====
`include "ppm_map.svh"

package ppm_pkg;

   // Which register an address phase selects, one-hot
   typedef enum logic [3:0] {
      PPM_SEL_NONE = 4'b0001,
      PPM_SEL_CSR  = 4'b0010,
      PPM_SEL_BRG  = 4'b0100,
      PPM_SEL_DATA = 4'b1000
   } ppm_sel_type;

   // Bus slave states, one-hot
   typedef enum logic [1:0] {
      PPM_BUS_IDLE = 2'b01,
      PPM_BUS_WAIT = 2'b10
   } ppm_bus_state_type;

   // Captured address phase
   typedef struct packed {
      logic write;
      ppm_sel_type sel;
   } ppm_acc_type;

   // Secondary bus controls
   typedef struct packed {
      logic clk_stop;
      logic pwr_off;
   } ppm_sec_type;

   // Address decode shared by the slave logic
   function automatic ppm_sel_type ppm_decode(input logic [31:0] a);
      ppm_sel_type s;
      s = PPM_SEL_NONE;
      if (a[31:10] != 22'h000000 || a[1:0] != 2'h0) begin
         s = PPM_SEL_NONE;
      end else if (a[9:2] == `PPM_IDX_CSR) begin
         s = PPM_SEL_CSR;
      end else if (a[9:2] == `PPM_IDX_BRG) begin
         s = PPM_SEL_BRG;
      end else if (a[9:2] == `PPM_IDX_DATA) begin
         s = PPM_SEL_DATA;
      end
      return s;
   endfunction

endpackage

// ==== rtl/ppm_wake.sv ====
`timescale 1ns/1ps

module ppm_wake
   import ppm_pkg::*;
(
   input wire logic hclk, // Bus clock
   input wire logic hresetn, // Async reset, active low
   input wire logic wake_src_pin, // Wake source level from outside
   input wire logic status_clr, // One-cycle write-one clear
   input wire logic wake_event_enable, // Event drive enable
   output logic wake_event_status, // Sticky event flag
   output logic pme_oe_n // Event pin enable, low drives
);

   ////////////////////////////////////////////////////////////////
   logic sync1_ff; // First synchroniser stage
   logic sync2_ff; // Second synchroniser stage
   logic prev_ff; // Previous synchronised level
   logic event_w; // Rising edge of the wake source
   logic status_ff; // Sticky flag
   logic oe_n_ff; // Pin enable
   logic nxt_status; // Next flag value

   // Two-stage synchroniser; the pin level is held by the source
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         sync1_ff <= wake_src_pin;
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
      end
   end

   assign event_w = sync2_ff & ~prev_ff;

   // Flag sets regardless of enable, set wins over clear
   always_comb begin
      nxt_status = status_ff;
      if (event_w) begin
         nxt_status = 1'b1;
      end else if (status_clr) begin
         nxt_status = 1'b0;
      end
   end

   // Flag register, cleared by the bus reset or by the write-one clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // Pin driven only while flag and enable are both set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oe_n_ff <= 1'b1;
      end else begin
         oe_n_ff <= ~(status_ff & wake_event_enable);
      end
   end

   assign wake_event_status = status_ff;
   assign pme_oe_n = oe_n_ff;

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_event_sets_flag: assert property (event_w |=> status_ff)
      else $error("wake event did not set flag");
   a_clear_flag: assert property (status_clr && !event_w |=> !status_ff)
      else $error("write one did not clear flag");
   a_clear_release: assert property (status_clr && !event_w |=> ##1 oe_n_ff)
      else $error("pin still driven after clear");
   a_pin_gated: assert property (!oe_n_ff |-> $past(status_ff & wake_event_enable))
      else $error("pin driven without enable and flag");
   c_pin_driven: cover property (event_w && wake_event_enable ##2 !oe_n_ff);

endmodule

// ==== rtl/ppm_top.sv ====
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps

// Offsets, field positions and reset values
`include "ppm_map.svh"

module ppm_top
   import ppm_pkg::*;
#(
   parameter logic [7:0] BRG_VALUE = `PPM_BRG_RST // Fixed bridge extension bits
)
(
   input wire logic hclk, // Bus clock, 200 MHz
   input wire logic hresetn, // Async reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size, word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic hreadyout, // Slave ready
   output logic [31:0] hrdata, // Read data
   output logic hresp, // Response, always OKAY
   input wire logic wake_src_pin, // Wake source level
   output logic pme_out, // Event pin output level
   output logic pme_oe_n, // Event pin enable, low drives
   output logic [1:0] device_power_state, // Current power state
   output logic func_reset_pulse, // Internal function reset
   output logic sec_clk_stop, // Secondary bus clock stopped
   output logic sec_pwr_off // Secondary bus power removed
);

   ////////////////////////////////////////////////////////////////
   // Fixed bridge bits
   localparam logic bpcc_on = BRG_VALUE[`PPM_BIT_BPCC]; // Power/clock control
   localparam logic d3_clk_stop = BRG_VALUE[`PPM_BIT_B2B3]; // Clock stop in D3hot
   localparam logic [7:0] data_value = `PPM_DATA_RST; // Data register value
   localparam logic [15:0] csr_rst = `PPM_CSR_RST; // Control/status reset

   ////////////////////////////////////////////////////////////////
   // Bus slave state
   ppm_bus_state_type bus_state_ff; // Slave state
   ppm_acc_type acc_ff; // Captured address phase
   logic hreadyout_ff; // Ready output
   logic [31:0] hrdata_ff; // Read data output
   logic hresp_ff; // Response output
   logic accept_w; // Address phase taken
   logic wr_csr_w; // Write to control/status completes
   logic rd_done_w; // Read completes

   // Control/status state
   logic wake_event_enable_ff; // Pin drive enable
   logic [1:0] power_state_ff; // Power state
   logic pulse_ff; // Function reset pulse
   logic status_clr_w; // Clear request to the wake logic
   logic wake_event_status; // Sticky flag from the wake logic
   logic pme_out_ff; // Open-drain level
   ppm_sec_type sec_ff; // Secondary bus controls
   ppm_sec_type nxt_sec; // Next secondary bus controls
   logic [31:0] nxt_rdata; // Read mux

   ////////////////////////////////////////////////////////////////
   // Address phase taken when selected and the bus is ready
   assign accept_w = hsel & htrans[1] & hready & (bus_state_ff == PPM_BUS_IDLE);

   // Data phase ends at the wait-state edge
   assign wr_csr_w = (bus_state_ff == PPM_BUS_WAIT) & acc_ff.write &
                     (acc_ff.sel == PPM_SEL_CSR);
   assign rd_done_w = (bus_state_ff == PPM_BUS_WAIT) & ~acc_ff.write;

   // Slave state machine, one wait state per transfer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state_ff <= PPM_BUS_IDLE;
         hreadyout_ff <= 1'b1;
      end else begin
         case (bus_state_ff)
            PPM_BUS_IDLE: begin
               // Insert the wait state
               if (accept_w) begin
                  bus_state_ff <= PPM_BUS_WAIT;
                  hreadyout_ff <= 1'b0;
               end
            end
            PPM_BUS_WAIT: begin
               // Finish the data phase
               bus_state_ff <= PPM_BUS_IDLE;
               hreadyout_ff <= 1'b1;
            end
            default: begin
               bus_state_ff <= PPM_BUS_IDLE;
               hreadyout_ff <= 1'b1;
            end
         endcase
      end
   end

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_ff <= '{write: 1'b0, sel: PPM_SEL_NONE};
      end else if (accept_w) begin
         acc_ff <= '{write: hwrite, sel: ppm_decode(haddr)};
      end
   end

   // Response is always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp_ff <= 1'b0;
      end else begin
         hresp_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read mux; unused fields and reserved bits are zero
   always_comb begin
      nxt_rdata = 32'h00000000;
      case (acc_ff.sel)
         PPM_SEL_CSR: begin
            nxt_rdata[`PPM_BIT_STATUS] = wake_event_status;
            nxt_rdata[`PPM_BIT_ENABLE] = wake_event_enable_ff;
            nxt_rdata[`PPM_PS_HI:`PPM_PS_LO] = power_state_ff;
         end
         PPM_SEL_BRG: begin
            // Fixed capability bits, low bits reserved
            nxt_rdata[`PPM_BIT_BPCC] = bpcc_on;
            nxt_rdata[`PPM_BIT_B2B3] = d3_clk_stop;
         end
         PPM_SEL_DATA: begin
            // No dynamic data is reported
            nxt_rdata[7:0] = data_value;
         end
         default: begin
            // Unmapped reads as zero
            nxt_rdata = 32'h00000000;
         end
      endcase
   end

   // Read data register, loaded as the read completes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h00000000;
      end else if (rd_done_w) begin
         hrdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Enable and power state; bus reset only, not the function pulse
   // Writes to the reserved fields and the other registers are dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_event_enable_ff <= csr_rst[`PPM_BIT_ENABLE];
         power_state_ff <= csr_rst[`PPM_PS_HI:`PPM_PS_LO];
      end else if (wr_csr_w) begin
         wake_event_enable_ff <= hwdata[`PPM_BIT_ENABLE];
         power_state_ff <= hwdata[`PPM_PS_HI:`PPM_PS_LO];
      end
   end

   // Write of one to the flag position requests a clear
   assign status_clr_w = wr_csr_w & hwdata[`PPM_BIT_STATUS];

   // One pulse on a D3hot to D0 move; other register groups use it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_ff <= 1'b0;
      end else begin
         pulse_ff <= wr_csr_w & (power_state_ff == `PPM_PS_D3) &
                     (hwdata[`PPM_PS_HI:`PPM_PS_LO] == `PPM_PS_D0);
      end
   end

   ////////////////////////////////////////////////////////////////
   // Secondary bus follows D3hot only when control is on
   always_comb begin
      nxt_sec = '{clk_stop: 1'b0, pwr_off: 1'b0};
      if (bpcc_on && power_state_ff == `PPM_PS_D3) begin
         if (d3_clk_stop) begin
            nxt_sec.clk_stop = 1'b1;
         end else begin
            nxt_sec.pwr_off = 1'b1;
         end
      end
   end

   // Secondary bus control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sec_ff <= '{clk_stop: 1'b0, pwr_off: 1'b0};
      end else begin
         sec_ff <= nxt_sec;
      end
   end

   // Open-drain pin only ever pulls low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pme_out_ff <= 1'b0;
      end else begin
         pme_out_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Wake event flag and pin drive
   ppm_wake u_wake (
      .hclk(hclk),
      .hresetn(hresetn),
      .wake_src_pin(wake_src_pin),
      .status_clr(status_clr_w),
      .wake_event_enable(wake_event_enable_ff),
      .wake_event_status(wake_event_status),
      .pme_oe_n(pme_oe_n)
   );

   ////////////////////////////////////////////////////////////////
   // Outputs
   assign hreadyout = hreadyout_ff;
   assign hrdata = hrdata_ff;
   assign hresp = hresp_ff;
   assign pme_out = pme_out_ff;
   assign device_power_state = power_state_ff;
   assign func_reset_pulse = pulse_ff;
   assign sec_clk_stop = sec_ff.clk_stop;
   assign sec_pwr_off = sec_ff.pwr_off;

   ////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Read of the control/status word completing
   logic rd_csr_w; // Read of control/status completes
   assign rd_csr_w = rd_done_w & (acc_ff.sel == PPM_SEL_CSR);

   a_bus_one_wait: assert property (accept_w |=> !hreadyout ##1 hreadyout)
      else $error("slave did not answer after one wait state");
   a_resp_okay: assert property (!hresp)
      else $error("slave gave a non-OKAY response");
   a_state_write: assert property (wr_csr_w |=>
      device_power_state == $past(hwdata[`PPM_PS_HI:`PPM_PS_LO]))
      else $error("power state not written");
   a_csr_zero_bits: assert property (rd_csr_w |=>
      hrdata[14:9] == 6'h00 && hrdata[7:2] == 6'h00 && hrdata[31:16] == 16'h0000)
      else $error("control/status fixed bits not zero");
   a_brg_read: assert property (rd_done_w && acc_ff.sel == PPM_SEL_BRG |=>
      hrdata == {24'h000000, BRG_VALUE})
      else $error("bridge extension read wrong");
   a_data_zero: assert property (rd_done_w && acc_ff.sel == PPM_SEL_DATA |=>
      hrdata == 32'h00000000)
      else $error("data register not zero");
   a_pulse_on_wake: assert property (wr_csr_w && power_state_ff == `PPM_PS_D3 &&
      hwdata[1:0] == `PPM_PS_D0 |=> func_reset_pulse ##1 !func_reset_pulse)
      else $error("function reset pulse missing or long");
   a_pulse_cause: assert property (func_reset_pulse |-> $past(wr_csr_w))
      else $error("function reset pulse without write");
   a_csr_survives: assert property (func_reset_pulse |=>
      device_power_state == $past(device_power_state))
      else $error("power state lost at function reset");
   a_sec_bus_d3: assert property (##1 sec_clk_stop ==
      $past(bpcc_on && d3_clk_stop && power_state_ff == `PPM_PS_D3))
      else $error("secondary bus clock control wrong");
   a_sec_bus_off: assert property (##1 sec_pwr_off ==
      $past(bpcc_on && !d3_clk_stop && power_state_ff == `PPM_PS_D3))
      else $error("secondary bus power control wrong");

   // Control off: the power state never reaches the secondary bus
   a_sec_bus_free: assert property (!bpcc_on |-> !sec_clk_stop && !sec_pwr_off)
      else $error("secondary bus touched with control disabled");
   // Power state moves only on a completed write, never on the pulse
   a_state_hold: assert property (!wr_csr_w |=> $stable(device_power_state))
      else $error("power state changed without a write");
   // Enable bit takes the written value
   a_enable_write: assert property (wr_csr_w |=>
      wake_event_enable_ff == $past(hwdata[`PPM_BIT_ENABLE]))
      else $error("event enable not written");
   // Flag seen by a read is the flag of that cycle
   a_status_read: assert property (rd_csr_w |=>
      hrdata[`PPM_BIT_STATUS] == $past(wake_event_status))
      else $error("event flag read wrong");
   // No pulse on any other power state write
   a_no_stray_pulse: assert property (wr_csr_w && !(power_state_ff == `PPM_PS_D3 &&
      hwdata[1:0] == `PPM_PS_D0) |=> !func_reset_pulse)
      else $error("function reset pulse on a wrong write");

   c_wake_from_d3: cover property (func_reset_pulse);
   c_csr_read: cover property (rd_csr_w);
   c_status_clear: cover property (status_clr_w && wake_event_status);

endmodule

// ==== verif/ppm_wake_src.sv ====
`timescale 1ns/1ps

// Far side: wake source and the pulled-up event line
module ppm_wake_src (
   input wire logic hclk, // Bus clock, used only to pace events
   input wire logic pme_out, // Level the device drives when enabled
   input wire logic pme_oe_n, // Low while the device drives the line
   output logic wake_src_pin, // Wake source level to the device
   output logic pme_line // Resolved event line
);
   // Line has a pull-up, so a released pin reads high
   assign pme_line = (pme_oe_n === 1'b0) ? pme_out : 1'b1;

   initial begin
      wake_src_pin = 1'b0;
   end

   // One event, launched on a clock edge like the rest of the stimulus
   task automatic fire();
      @(posedge hclk);
      wake_src_pin <= 1'b1;
      repeat (3) @(posedge hclk);
      wake_src_pin <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask
endmodule

// ==== verif/ppm_top_bench.sv ====
`timescale 1ns/1ps

module ppm_top_bench
   import ppm_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, dps;
   logic [2:0] hsize;
   logic wake_pin, pme_out, pme_oe_n, pulse, clk_stop, pwr_off, pme_line;
   logic clk_stop_b3, pwr_off_b3, clk_stop_off, pwr_off_off; // Variant bridge outputs
   logic [31:0] exp_q[$]; // Expected read data, oldest first
   logic rd_pend; // A read is in its data phase
   int bad_count, total_checks, cyc, pulses, exp_pulses;
   logic [31:0] rnd;
   logic [1:0] cur_ps;
   localparam logic [31:0] A_CSR = 32'h00000290; // Control/status word
   localparam logic [31:0] A_BRG = 32'h00000298; // Bridge extensions word
   localparam logic [31:0] A_DAT = 32'h0000029C; // Report data word

   ppm_top dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .wake_src_pin(wake_pin),
      .pme_out(pme_out), .pme_oe_n(pme_oe_n), .device_power_state(dps),
      .func_reset_pulse(pulse), .sec_clk_stop(clk_stop), .sec_pwr_off(pwr_off)
   );

   // Power removal in D3hot; bus inputs shared with the main instance, bus outputs left open
   ppm_top #(.BRG_VALUE(8'h80)) dut_b3_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(), .hrdata(), .hresp(), .wake_src_pin(wake_pin),
      .pme_out(), .pme_oe_n(), .device_power_state(),
      .func_reset_pulse(), .sec_clk_stop(clk_stop_b3), .sec_pwr_off(pwr_off_b3)
   );

   // Power/clock control disabled
   ppm_top #(.BRG_VALUE(8'h40)) dut_off_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(), .hrdata(), .hresp(), .wake_src_pin(wake_pin),
      .pme_out(), .pme_oe_n(), .device_power_state(),
      .func_reset_pulse(), .sec_clk_stop(clk_stop_off), .sec_pwr_off(pwr_off_off)
   );

   ppm_wake_src wk_u (
      .hclk(hclk), .pme_out(pme_out), .pme_oe_n(pme_oe_n),
      .wake_src_pin(wake_pin), .pme_line(pme_line)
   );

   ////////////////////////////////////////////////////////////////
   // Clock, 5 ns period
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // Comparison with count and report
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask

   // Verdict and end of run
   task automatic conclude();
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Pseudo-random step
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   ////////////////////////////////////////////////////////////////
   // One single word transfer; reads note their expected data
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [31:0] e);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      if (!w) begin
         exp_q.push_back(e);
      end
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   // Write to the control/status word, tracking reset pulses
   task automatic wr_csr(input logic [31:0] d);
      if (cur_ps == 2'h3 && d[1:0] == 2'h0) begin
         exp_pulses++;
      end
      cur_ps = d[1:0];
      xfer(1'b1, A_CSR, d, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////
   // Read monitor: takes the oldest note when a read completes
   always @(posedge hclk) begin
      if (rd_pend && hreadyout === 1'b1) begin
         rd_pend = 1'b0;
         if (exp_q.size() == 0) begin
            chk(hrdata, 32'hDEADBEEF);
         end else begin
            chk(hrdata, exp_q.pop_front());
         end
         chk({31'h0, hresp}, 32'h0);
      end
      if (hsel && htrans[1] && hreadyout === 1'b1 && !hwrite) begin
         rd_pend = 1'b1;
      end
   end

   // Reset pulse counter, one count per cycle high
   always @(posedge hclk) begin
      if (pulse === 1'b1) begin
         pulses++;
      end
   end

   // Hang guard
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rd_pend = 1'b0;
      rnd = 32'hF08821D2;
      cur_ps = 2'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values and fixed registers
      xfer(1'b0, A_CSR, 32'h0, 32'h0);
      xfer(1'b0, A_BRG, 32'h0, 32'h000000C0);
      xfer(1'b1, A_BRG, 32'hFFFFFFFF, 32'h0);
      xfer(1'b1, A_DAT, 32'hFFFFFFFF, 32'h0);
      xfer(1'b0, A_BRG, 32'h0, 32'h000000C0);
      xfer(1'b0, A_DAT, 32'h0, 32'h0);
      xfer(1'b0, 32'h000002A0, 32'h0, 32'h0);
      // Every power state code, read back and on the port
      for (int i = 0; i < 4; i++) begin
         wr_csr(32'hFFFF7E00 | i);
         xfer(1'b0, A_CSR, 32'h0, i);
         chk({30'h0, dps}, i);
      end
      @(posedge hclk);
      chk({30'h0, clk_stop, pwr_off}, 32'h2);
      chk({30'h0, clk_stop_b3, pwr_off_b3}, 32'h1);
      chk({30'h0, clk_stop_off, pwr_off_off}, 32'h0);
      // Event while disabled: flag sets, line stays released
      wk_u.fire();
      repeat (3) @(posedge hclk);
      chk({31'h0, pme_line}, 32'h1);
      xfer(1'b0, A_CSR, 32'h0, 32'h00008003);
      // Leave D3hot with enable on; flag written as zero survives
      wr_csr(32'h00000100);
      xfer(1'b0, A_CSR, 32'h0, 32'h00008100);
      chk(pulses, exp_pulses);
      chk({30'h0, clk_stop, pwr_off}, 32'h0);
      chk({30'h0, clk_stop_b3, pwr_off_b3}, 32'h0);
      // Write one clears the flag and releases the line
      wr_csr(32'h00008100);
      repeat (2) @(posedge hclk);
      chk({31'h0, pme_line}, 32'h1);
      xfer(1'b0, A_CSR, 32'h0, 32'h00000100);
      // Event while enabled drives the line low
      wk_u.fire();
      repeat (3) @(posedge hclk);
      chk({31'h0, pme_line}, 32'h0);
      xfer(1'b0, A_CSR, 32'h0, 32'h00008100);
      wr_csr(32'h00008000);
      repeat (2) @(posedge hclk);
      chk({31'h0, pme_line}, 32'h1);
      xfer(1'b0, A_CSR, 32'h0, 32'h0);
      // Random writes; only enable and state may stick
      repeat (12) begin
         rnd = lfsr(rnd);
         wr_csr(rnd);
         xfer(1'b0, A_CSR, 32'h0, rnd & 32'h00000103);
         chk({30'h0, dps}, rnd[1:0]);
      end
      chk(pulses, exp_pulses);
      // Second reset clears the writable bits
      wr_csr(32'h00000103);
      hresetn <= 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      cur_ps = 2'h0;
      xfer(1'b0, A_CSR, 32'h0, 32'h0);
      chk({31'h0, pme_line}, 32'h1);
      repeat (2) @(posedge hclk);
      chk(exp_q.size(), 0);
      conclude();
   end
endmodule
